// ### gotr_consts.svh
// Register offsets, field positions, reset values and timing counts of the offset trim bank.
`ifndef GOTR_CONSTS_SVH
`define GOTR_CONSTS_SVH

`define GOTR_ADDR_NVM_CTRL 8'h33
`define GOTR_ADDR_OFS_MID 8'h36
`define GOTR_ADDR_OFS_X_HI 8'h37
`define GOTR_ADDR_OFS_Y_HI 8'h38
`define GOTR_ADDR_OFS_Z_HI 8'h39
`define GOTR_ADDR_SPARE_LOW 8'h3A
`define GOTR_ADDR_SPARE_BYTE 8'h3B

`define GOTR_CTRL_PROG_MODE_BIT 0
`define GOTR_CTRL_PROG_TRIG_BIT 1
`define GOTR_CTRL_READY_BIT 2
`define GOTR_CTRL_LOAD_BIT 3
`define GOTR_CTRL_REMAIN_LSB 4
`define GOTR_CTRL_REMAIN_MSB 7

`define GOTR_MID_X_MSB 7
`define GOTR_MID_X_LSB 6
`define GOTR_MID_Y_MSB 5
`define GOTR_MID_Y_LSB 3
`define GOTR_MID_Z_MSB 2
`define GOTR_MID_Z_LSB 0
`define GOTR_LOW_SPARE_MSB 7
`define GOTR_LOW_SPARE_LSB 4
`define GOTR_LOW_X_MSB 3
`define GOTR_LOW_X_LSB 2
`define GOTR_LOW_Y_BIT 1
`define GOTR_LOW_Z_BIT 0

`define GOTR_OFS_RESET 12'h000
`define GOTR_SPARE_NIBBLE_RESET 4'h0
`define GOTR_SPARE_BYTE_RESET 8'h00
`define GOTR_NVM_REMAIN_RESET 4'hF
`define GOTR_NVM_IMAGE_RESET 48'h000000000000
`define GOTR_NVM_BYTES 6
`define GOTR_RANGE_MAX 3'h4

`define GOTR_CLK_PERIOD_PS 5000
`define GOTR_NVM_LOAD_TIME_NS 500
`define GOTR_NVM_LOAD_CYCLES ((`GOTR_NVM_LOAD_TIME_NS * 1000 + `GOTR_CLK_PERIOD_PS - 1) / `GOTR_CLK_PERIOD_PS)
`define GOTR_NVM_PROG_TIME_US 10000
`define GOTR_NVM_PROG_CYCLES ((`GOTR_NVM_PROG_TIME_US * 1000 + `GOTR_CLK_PERIOD_PS / 1000 - 1) / (`GOTR_CLK_PERIOD_PS / 1000))

`endif

// ### gotr_pkg.sv
// Types shared by the offset trim bank.
package gotr_pkg;

  typedef enum logic [1:0] {
    GOTR_NVM_IDLE,
    GOTR_NVM_LOADING,
    GOTR_NVM_PROGRAMMING
  } gotr_nvm_state_t;

  typedef logic [11:0] gotr_offset_t;
  typedef logic [47:0] gotr_image_t;

endpackage

// ### gotr_nvm_store.sv
// Non-volatile image store with timed load and program operations.
`timescale 1ns/1ps
`default_nettype none
`include "gotr_consts.svh"

module gotr_nvm_store #(
  parameter int unsigned LOAD_CYCLES = 100,
  parameter int unsigned PROG_CYCLES = 2000000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Operation requests, accepted only while idle.
  input wire logic load_start,
  input wire logic prog_start,
  input wire gotr_pkg::gotr_image_t prog_image,
  // Status and load result.
  output logic busy,
  output logic load_done,
  output gotr_pkg::gotr_image_t load_image
);

  logic [7:0] mem [0:`GOTR_NVM_BYTES-1];
  logic [23:0] count_reg;
  logic loading_reg;
  logic programming_reg;
  logic last_cycle;

  assign last_cycle = (count_reg == 24'h000001);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_reg <= 24'h000000;
      loading_reg <= 1'b0;
      programming_reg <= 1'b0;
    end
    else if (!loading_reg && !programming_reg)
    begin
      if (load_start)
      begin
        loading_reg <= 1'b1;
        count_reg <= LOAD_CYCLES[23:0];
      end
      else if (prog_start)
      begin
        programming_reg <= 1'b1;
        count_reg <= PROG_CYCLES[23:0];
      end
    end
    else if (last_cycle)
    begin
      loading_reg <= 1'b0;
      programming_reg <= 1'b0;
      count_reg <= 24'h000000;
    end
    else
    begin
      count_reg <= count_reg - 24'h000001;
    end
  end

  // The image is captured when the program starts, so later writes do not leak in.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `GOTR_NVM_BYTES; i++)
      begin
        mem[i] <= 8'(`GOTR_NVM_IMAGE_RESET >> (8 * i));
      end
    end
    else if (!loading_reg && !programming_reg && !load_start && prog_start)
    begin
      for (int i = 0; i < `GOTR_NVM_BYTES; i++)
      begin
        mem[i] <= prog_image[8*i +: 8];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      load_done <= 1'b0;
      load_image <= `GOTR_NVM_IMAGE_RESET;
    end
    else
    begin
      load_done <= loading_reg && last_cycle;
      if (loading_reg && last_cycle)
      begin
        for (int i = 0; i < `GOTR_NVM_BYTES; i++)
        begin
          load_image[8*i +: 8] <= mem[i];
        end
      end
    end
  end

  assign busy = loading_reg || programming_reg;

endmodule
`default_nettype wire

// ### gotr_axis_comp.sv
// One axis of offset compensation on filtered and unfiltered rate data.
`timescale 1ns/1ps
`default_nettype none
`include "gotr_consts.svh"

module gotr_axis_comp (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Raw sample in.
  input wire logic sample_valid,
  input wire logic [15:0] filt_in,
  input wire logic [15:0] unfilt_in,
  // Offset and range.
  input wire gotr_pkg::gotr_offset_t offset,
  input wire logic [2:0] range_sel,
  // Compensated sample out.
  output logic comp_valid,
  output logic [15:0] filt_out,
  output logic [15:0] unfilt_out
);

  logic [2:0] shift;
  logic [19:0] ofs_scaled;

  function automatic logic [15:0] sub_sat(input logic [15:0] data, input logic [19:0] ofs);
    logic [19:0] diff;
    diff = {{4{data[15]}}, data} - ofs;
    if (diff[19:15] == 5'h00 || diff[19:15] == 5'h1F)
      sub_sat = diff[15:0];
    else if (diff[19])
      sub_sat = 16'h8000;
    else
      sub_sat = 16'h7FFF;
  endfunction

  // The offset step is fixed in deg/s, so it grows by one bit per halving of the range.
  assign shift = (range_sel > `GOTR_RANGE_MAX) ? `GOTR_RANGE_MAX : range_sel;
  assign ofs_scaled = {{8{offset[11]}}, offset} << shift;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      comp_valid <= 1'b0;
      filt_out <= 16'h0000;
      unfilt_out <= 16'h0000;
    end
    else
    begin
      comp_valid <= sample_valid;
      if (sample_valid)
      begin
        filt_out <= sub_sat(filt_in, ofs_scaled);
        unfilt_out <= sub_sat(unfilt_in, ofs_scaled);
      end
    end
  end

endmodule
`default_nettype wire

// ### gotr_regs.sv
// Offset compensation register bank with non-volatile image control.
`timescale 1ns/1ps
`default_nettype none
`include "gotr_consts.svh"

// What this block does
// - High offset bytes, one register per axis.
// - Middle offset bits packed in shared register.
// - Lowest offset bits in trim low nibble.
// - Subtract offset from filtered and unfiltered data.
// - Offsets are twelve-bit two's complement.
// - Reload image after power-on and soft reset.
// - Host writes override until next reload or calibration result.
// - Programming stores current register contents.
// - Spare nibble, no sensor effect; reload takes lowest offset bits from spare byte.
// - Spare byte restored from stored image; nibble from that byte's upper half.
// - Ready low during image write or reload.
// - Load trigger refreshes registers from image.
module gotr_regs #(
  parameter int unsigned NVM_PROG_CYCLES = `GOTR_NVM_PROG_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  input wire logic soft_reset,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Calibration engine results.
  input wire logic cal_valid,
  input wire gotr_pkg::gotr_offset_t cal_x,
  input wire gotr_pkg::gotr_offset_t cal_y,
  input wire gotr_pkg::gotr_offset_t cal_z,
  // Raw rate samples.
  input wire logic sample_valid,
  input wire logic [2:0] range_sel,
  input wire logic [15:0] x_filt_in,
  input wire logic [15:0] x_unfilt_in,
  input wire logic [15:0] y_filt_in,
  input wire logic [15:0] y_unfilt_in,
  input wire logic [15:0] z_filt_in,
  input wire logic [15:0] z_unfilt_in,
  // Compensated rate samples.
  output logic comp_valid,
  output logic [15:0] x_filt_out,
  output logic [15:0] x_unfilt_out,
  output logic [15:0] y_filt_out,
  output logic [15:0] y_unfilt_out,
  output logic [15:0] z_filt_out,
  output logic [15:0] z_unfilt_out,
  // Image controller status.
  output logic nvm_ready
);

  gotr_pkg::gotr_offset_t ofs_x_reg;
  gotr_pkg::gotr_offset_t ofs_y_reg;
  gotr_pkg::gotr_offset_t ofs_z_reg;
  logic [3:0] spare_user_nibble_reg;
  logic [7:0] spare_user_byte_reg;
  logic prog_mode_reg;
  logic load_flag_reg;
  logic [3:0] remain_reg;
  logic auto_load_pend_reg;
  gotr_pkg::gotr_nvm_state_t state_reg;
  gotr_pkg::gotr_nvm_state_t state_next;

  logic wr_ctrl;
  logic wr_mid;
  logic wr_x_hi;
  logic wr_y_hi;
  logic wr_z_hi;
  logic wr_low;
  logic wr_byte;
  logic host_load_req;
  logic host_prog_req;
  logic load_start;
  logic prog_start;
  logic store_busy;
  logic load_done;
  gotr_pkg::gotr_image_t load_image;
  gotr_pkg::gotr_image_t cur_image;
  logic [7:0] mid_byte;
  logic [7:0] low_byte;
  logic [7:0] ctrl_byte;
  logic [7:0] rd_next;
  logic x_valid;

  // Register byte views.
  always_comb
  begin
    mid_byte = 8'h00;
    mid_byte[`GOTR_MID_X_MSB:`GOTR_MID_X_LSB] = ofs_x_reg[3:2];
    mid_byte[`GOTR_MID_Y_MSB:`GOTR_MID_Y_LSB] = ofs_y_reg[3:1];
    mid_byte[`GOTR_MID_Z_MSB:`GOTR_MID_Z_LSB] = ofs_z_reg[3:1];
  end

  always_comb
  begin
    low_byte = 8'h00;
    low_byte[`GOTR_LOW_SPARE_MSB:`GOTR_LOW_SPARE_LSB] = spare_user_nibble_reg;
    low_byte[`GOTR_LOW_X_MSB:`GOTR_LOW_X_LSB] = ofs_x_reg[1:0];
    low_byte[`GOTR_LOW_Y_BIT] = ofs_y_reg[0];
    low_byte[`GOTR_LOW_Z_BIT] = ofs_z_reg[0];
  end

  always_comb
  begin
    ctrl_byte = 8'h00;
    ctrl_byte[`GOTR_CTRL_REMAIN_MSB:`GOTR_CTRL_REMAIN_LSB] = remain_reg;
    ctrl_byte[`GOTR_CTRL_LOAD_BIT] = load_flag_reg;
    ctrl_byte[`GOTR_CTRL_READY_BIT] = nvm_ready;
    ctrl_byte[`GOTR_CTRL_PROG_MODE_BIT] = prog_mode_reg;
  end

  assign cur_image = {spare_user_byte_reg, low_byte, ofs_z_reg[11:4], ofs_y_reg[11:4],
                      ofs_x_reg[11:4], mid_byte};

  // Write decode.
  assign wr_ctrl = reg_wr && (reg_addr == `GOTR_ADDR_NVM_CTRL);
  assign wr_mid = reg_wr && (reg_addr == `GOTR_ADDR_OFS_MID);
  assign wr_x_hi = reg_wr && (reg_addr == `GOTR_ADDR_OFS_X_HI);
  assign wr_y_hi = reg_wr && (reg_addr == `GOTR_ADDR_OFS_Y_HI);
  assign wr_z_hi = reg_wr && (reg_addr == `GOTR_ADDR_OFS_Z_HI);
  assign wr_low = reg_wr && (reg_addr == `GOTR_ADDR_SPARE_LOW);
  assign wr_byte = reg_wr && (reg_addr == `GOTR_ADDR_SPARE_BYTE);

  assign host_load_req = wr_ctrl && reg_wdata[`GOTR_CTRL_LOAD_BIT];
  assign host_prog_req = wr_ctrl && reg_wdata[`GOTR_CTRL_PROG_TRIG_BIT]
                         && prog_mode_reg && (remain_reg != 4'h0);

  // Triggers are taken only while idle; a load outranks a program in the same cycle.
  // triggers only when idle
  assign load_start = (state_reg == gotr_pkg::GOTR_NVM_IDLE)
                      && (auto_load_pend_reg || host_load_req);
  assign prog_start = (state_reg == gotr_pkg::GOTR_NVM_IDLE) && !load_start && host_prog_req;

  // Image controller sequence.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      gotr_pkg::GOTR_NVM_IDLE:
      begin
        if (load_start)
          state_next = gotr_pkg::GOTR_NVM_LOADING;
        else if (prog_start)
          state_next = gotr_pkg::GOTR_NVM_PROGRAMMING;
      end
      gotr_pkg::GOTR_NVM_LOADING:
      begin
        if (load_done)
          state_next = gotr_pkg::GOTR_NVM_IDLE;
      end
      gotr_pkg::GOTR_NVM_PROGRAMMING:
      begin
        if (!store_busy)
          state_next = gotr_pkg::GOTR_NVM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= gotr_pkg::GOTR_NVM_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      nvm_ready <= 1'b0;
    else
      nvm_ready <= (state_next == gotr_pkg::GOTR_NVM_IDLE) && !auto_load_pend_reg
                   && !(soft_reset);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      auto_load_pend_reg <= 1'b1;
    else
      auto_load_pend_reg <= soft_reset || (auto_load_pend_reg && !load_start);
  end

  // Control fields.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prog_mode_reg <= 1'b0;
    else if (wr_ctrl)
      prog_mode_reg <= reg_wdata[`GOTR_CTRL_PROG_MODE_BIT];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      load_flag_reg <= 1'b0;
    else if (load_start && host_load_req)
      load_flag_reg <= 1'b1;
    else if (load_done)
      load_flag_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      remain_reg <= `GOTR_NVM_REMAIN_RESET;
    else if (prog_start)
      remain_reg <= remain_reg - 4'h1;
  end

  // Offset fields: a host write wins over a reload result, which wins over calibration.
  // per-axis offset registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ofs_x_reg <= `GOTR_OFS_RESET;
    else
    begin
      if (load_done)
        ofs_x_reg <= {load_image[15:8], load_image[`GOTR_MID_X_MSB:`GOTR_MID_X_LSB],
                      load_image[40+`GOTR_LOW_X_MSB:40+`GOTR_LOW_X_LSB]};
      else if (cal_valid)
        ofs_x_reg <= cal_x;
      if (wr_x_hi)
        ofs_x_reg[11:4] <= reg_wdata;
      if (wr_mid)
        ofs_x_reg[3:2] <= reg_wdata[`GOTR_MID_X_MSB:`GOTR_MID_X_LSB];
      if (wr_low)
        ofs_x_reg[1:0] <= reg_wdata[`GOTR_LOW_X_MSB:`GOTR_LOW_X_LSB];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ofs_y_reg <= `GOTR_OFS_RESET;
    else
    begin
      if (load_done)
        ofs_y_reg <= {load_image[23:16], load_image[`GOTR_MID_Y_MSB:`GOTR_MID_Y_LSB],
                      load_image[40+`GOTR_LOW_Y_BIT]};
      else if (cal_valid)
        ofs_y_reg <= cal_y;
      if (wr_y_hi)
        ofs_y_reg[11:4] <= reg_wdata;
      if (wr_mid)
        ofs_y_reg[3:1] <= reg_wdata[`GOTR_MID_Y_MSB:`GOTR_MID_Y_LSB];
      if (wr_low)
        ofs_y_reg[0] <= reg_wdata[`GOTR_LOW_Y_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ofs_z_reg <= `GOTR_OFS_RESET;
    else
    begin
      if (load_done)
        ofs_z_reg <= {load_image[31:24], load_image[`GOTR_MID_Z_MSB:`GOTR_MID_Z_LSB],
                      load_image[40+`GOTR_LOW_Z_BIT]};
      else if (cal_valid)
        ofs_z_reg <= cal_z;
      if (wr_z_hi)
        ofs_z_reg[11:4] <= reg_wdata;
      if (wr_mid)
        ofs_z_reg[3:1] <= reg_wdata[`GOTR_MID_Z_MSB:`GOTR_MID_Z_LSB];
      if (wr_low)
        ofs_z_reg[0] <= reg_wdata[`GOTR_LOW_Z_BIT];
    end
  end

  // Spare storage feeds nothing but readback and the image.
  // spare fields
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      spare_user_nibble_reg <= `GOTR_SPARE_NIBBLE_RESET;
    else if (wr_low)
      spare_user_nibble_reg <= reg_wdata[`GOTR_LOW_SPARE_MSB:`GOTR_LOW_SPARE_LSB];
    else if (load_done)
      spare_user_nibble_reg <= load_image[40+`GOTR_LOW_SPARE_MSB:40+`GOTR_LOW_SPARE_LSB];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      spare_user_byte_reg <= `GOTR_SPARE_BYTE_RESET;
    else if (wr_byte)
      spare_user_byte_reg <= reg_wdata;
    else if (load_done)
      spare_user_byte_reg <= load_image[47:40];
  end

  // Read path; unmapped addresses read zero.
  always_comb
  begin
    rd_next = 8'h00;
    unique case (reg_addr)
      `GOTR_ADDR_NVM_CTRL: rd_next = ctrl_byte;
      `GOTR_ADDR_OFS_MID: rd_next = mid_byte;
      `GOTR_ADDR_OFS_X_HI: rd_next = ofs_x_reg[11:4];
      `GOTR_ADDR_OFS_Y_HI: rd_next = ofs_y_reg[11:4];
      `GOTR_ADDR_OFS_Z_HI: rd_next = ofs_z_reg[11:4];
      `GOTR_ADDR_SPARE_LOW: rd_next = low_byte;
      `GOTR_ADDR_SPARE_BYTE: rd_next = spare_user_byte_reg;
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_next;
    else
      reg_rdata <= 8'h00;
  end

  gotr_nvm_store #(
    .LOAD_CYCLES(`GOTR_NVM_LOAD_CYCLES),
    .PROG_CYCLES(NVM_PROG_CYCLES)
  ) u_store (
    .clk(clk),
    .resetn(resetn),
    .load_start(load_start),
    .prog_start(prog_start),
    .prog_image(cur_image),
    .busy(store_busy),
    .load_done(load_done),
    .load_image(load_image)
  );

  gotr_axis_comp u_axis_x (
    .clk(clk),
    .resetn(resetn),
    .sample_valid(sample_valid),
    .filt_in(x_filt_in),
    .unfilt_in(x_unfilt_in),
    .offset(ofs_x_reg),
    .range_sel(range_sel),
    .comp_valid(x_valid),
    .filt_out(x_filt_out),
    .unfilt_out(x_unfilt_out)
  );

  gotr_axis_comp u_axis_y (
    .clk(clk),
    .resetn(resetn),
    .sample_valid(sample_valid),
    .filt_in(y_filt_in),
    .unfilt_in(y_unfilt_in),
    .offset(ofs_y_reg),
    .range_sel(range_sel),
    .comp_valid(),
    .filt_out(y_filt_out),
    .unfilt_out(y_unfilt_out)
  );

  gotr_axis_comp u_axis_z (
    .clk(clk),
    .resetn(resetn),
    .sample_valid(sample_valid),
    .filt_in(z_filt_in),
    .unfilt_in(z_unfilt_in),
    .offset(ofs_z_reg),
    .range_sel(range_sel),
    .comp_valid(),
    .filt_out(z_filt_out),
    .unfilt_out(z_unfilt_out)
  );

  // All three axes share one valid, so the X flop alone gives the sample strobe.
  assign comp_valid = x_valid;

endmodule
`default_nettype wire

// ### gotr_regs_monitor.sv
// Concurrent checks on the ports of the offset trim register bank.
`timescale 1ns/1ps
`default_nettype none

module gotr_regs_monitor #(
  parameter int unsigned NVM_PROG_CYCLES = 20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  input wire logic soft_reset,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Sample path and status.
  input wire logic sample_valid,
  input wire logic comp_valid,
  input wire logic [15:0] x_filt_out,
  input wire logic [15:0] z_unfilt_out,
  input wire logic nvm_ready
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic unmapped;
  assign unmapped = !(reg_addr == 8'h33 || (reg_addr >= 8'h36 && reg_addr <= 8'h3B));

  localparam int unsigned BUSY_LIMIT = NVM_PROG_CYCLES + 110;
  int unsigned busy_cnt;

  // Counts the length of the current busy stretch, so a hung controller is caught.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      busy_cnt <= 32'd0;
    else if (nvm_ready)
      busy_cnt <= 32'd0;
    else
      busy_cnt <= busy_cnt + 32'd1;
  end

  a_rdata_only_after: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data present without a read");
  a_unmapped_reads_zero: assert property (reg_rd && unmapped |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_write_read_back: assert property ((reg_wr && reg_addr == 8'h37 && nvm_ready && !soft_reset)
    ##1 (reg_rd && reg_addr == 8'h37) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("x high byte not read back");
  a_comp_follows_sample: assert property (sample_valid |=> comp_valid)
    else $error("no compensated sample after raw sample");
  a_comp_no_spurious: assert property (!sample_valid |=> !comp_valid)
    else $error("compensated sample without raw sample");
  a_outputs_hold: assert property (!sample_valid |=> $stable(x_filt_out) && $stable(z_unfilt_out))
    else $error("outputs changed between samples");
  a_soft_reset_busy: assert property (soft_reset |=> !nvm_ready)
    else $error("ready stayed high after soft reset");
  a_load_trig_busy: assert property (reg_wr && reg_addr == 8'h33 && reg_wdata[3] && nvm_ready
    |=> !nvm_ready)
    else $error("ready stayed high after load trigger");
  a_busy_min_len: assert property ($fell(nvm_ready) |-> !nvm_ready [*8])
    else $error("ready low pulse too short");
  a_busy_bounded: assert property (busy_cnt <= BUSY_LIMIT)
    else $error("ready did not return");

  c_soft_reset: cover property (soft_reset ##1 !nvm_ready);
  c_load_trig: cover property (reg_wr && reg_addr == 8'h33 && reg_wdata[3] && nvm_ready);
  c_sample: cover property (sample_valid ##1 comp_valid);
endmodule

bind gotr_regs gotr_regs_monitor #(.NVM_PROG_CYCLES(NVM_PROG_CYCLES)) u_mon (
  .clk(clk), .resetn(resetn), .soft_reset(soft_reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sample_valid(sample_valid), .comp_valid(comp_valid), .x_filt_out(x_filt_out),
  .z_unfilt_out(z_unfilt_out), .nvm_ready(nvm_ready)
);
`default_nettype wire

// ### gotr_regs_test.sv
// Self-checking testbench of the offset trim register bank.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module gotr_regs_test;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} gotr_row_t;
  logic clk = 1'b0, resetn = 1'b0, soft_reset = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cal_valid = 1'b0, sample_valid = 1'b0;
  logic [11:0] cal_x = 12'h000, cal_y = 12'h000, cal_z = 12'h000;
  logic [2:0] range_sel = 3'h0;
  logic [15:0] fin = 16'h0000, uin = 16'h0000;
  logic comp_valid, nvm_ready;
  logic [15:0] xf, xu, yf, yu, zf, zu;
  int error_cnt = 0, checks = 0;
  gotr_row_t rows [9] = '{'{8'h36, 8'hC0, 8'hC0}, '{8'h37, 8'h7F, 8'h7F},
    '{8'h38, 8'h80, 8'h80}, '{8'h39, 8'h00, 8'h00}, '{8'h3A, 8'hFD, 8'hFD},
    '{8'h3B, 8'hA5, 8'hA5}, '{8'h35, 8'hFF, 8'h00}, '{8'h3C, 8'h12, 8'h00},
    '{8'h33, 8'h00, 8'hF4}};

  always #2.5 clk = ~clk;

  gotr_regs #(.NVM_PROG_CYCLES(20)) dut (
    .clk(clk), .resetn(resetn), .soft_reset(soft_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cal_valid(cal_valid), .cal_x(cal_x), .cal_y(cal_y), .cal_z(cal_z),
    .sample_valid(sample_valid), .range_sel(range_sel), .x_filt_in(fin), .x_unfilt_in(uin),
    .y_filt_in(fin), .y_unfilt_in(uin), .z_filt_in(fin), .z_unfilt_in(uin),
    .comp_valid(comp_valid), .x_filt_out(xf), .x_unfilt_out(xu), .y_filt_out(yf),
    .y_unfilt_out(yu), .z_filt_out(zf), .z_unfilt_out(zu), .nvm_ready(nvm_ready)
  );

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Each bus task starts just after a rising edge and ends on one.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask

  task automatic samp(input logic [2:0] r, input logic [15:0] f, input logic [15:0] u);
    sample_valid <= 1'b1;
    range_sel <= r;
    fin <= f;
    uin <= u;
    @(posedge clk);
    sample_valid <= 1'b0;
    #1 `CHK(comp_valid, 1'b1)
    @(posedge clk);
  endtask

  // Expects the controller busy one cycle on, then waits for it to finish.
  task automatic wait_ready();
    int n;
    @(posedge clk);
    #1 `CHK(nvm_ready, 1'b0)
    for (n = 0; n < 200 && nvm_ready !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    if (nvm_ready !== 1'b1)
    begin
      error_cnt++;
      report_and_stop();
    end
    @(posedge clk);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    wait_ready();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d);
      `CHK(d, rows[i].e)
    end
    // Offsets now X=2047, Y=-2048, Z=1 with spare nibble set.
    samp(3'h0, 16'h0000, 16'h7FFF);
    `CHK({xf, xu, yf, yu}, {16'hF801, 16'h7800, 16'h0800, 16'h7FFF})
    `CHK({zf, zu}, {16'hFFFF, 16'h7FFE})
    samp(3'h4, 16'h0000, 16'h7FFF);
    `CHK({xf, xu, yf, zf}, {16'h8010, 16'h000F, 16'h7FFF, 16'hFFF0})
    samp(3'h7, 16'h0000, 16'h7FFF);
    `CHK({xf, xu, yf, zf}, {16'h8010, 16'h000F, 16'h7FFF, 16'hFFF0})
    wr(8'h39, 8'h01);
    samp(3'h0, 16'h0000, 16'h7FFF);
    `CHK(zf, 16'hFFEF)
    cal_x <= 12'hABC;
    cal_y <= 12'h123;
    cal_z <= 12'h456;
    cal_valid <= 1'b1;
    @(posedge clk);
    cal_valid <= 1'b0;
    rd(8'h37, d);
    `CHK(d, 8'hAB)
    rd(8'h39, d);
    `CHK(d, 8'h45)
    wr(8'h37, 8'h5A);
    @(posedge clk);
    wr(8'h3B, 8'h3C);
    @(posedge clk);
    wr(8'h33, 8'h01);
    @(posedge clk);
    wr(8'h33, 8'h03);
    wait_ready();
    wr(8'h37, 8'h00);
    @(posedge clk);
    wr(8'h3B, 8'h00);
    @(posedge clk);
    wr(8'h33, 8'h08);
    wait_ready();
    rd(8'h37, d);
    `CHK(d, 8'h5A)
    rd(8'h3B, d);
    `CHK(d, 8'h3C)
    rd(8'h33, d);
    `CHK(d[7:4], 4'hE)
    // Program without unlock must be refused.
    wr(8'h33, 8'h02);
    repeat (2) @(posedge clk);
    rd(8'h33, d);
    `CHK({d[7:4], d[2]}, 5'h1D)
    wr(8'h37, 8'h11);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    wait_ready();
    rd(8'h37, d);
    `CHK(d, 8'h5A)
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    wait_ready();
    rd(8'h3B, d);
    `CHK(d, 8'h00)
    rd(8'h37, d);
    `CHK(d, 8'h00)
    report_and_stop();
  end
endmodule
`default_nettype wire
